// *** alu_pkg.sv ***
// constants, types and register map of the shift/logic/bit datapath
// assumes a single 100 MHz core clock and an Avalon-MM register bus
package alu_pkg;
	localparam int DATA_W = 8;
	localparam int MSB = DATA_W - 1;
	localparam int NIB = DATA_W / 2;
	localparam int BUS_W = 32;
	localparam int ADDR_W = 8;
	localparam int ALIGN_W = 2;
	localparam int MEM_ADDR_W = 4;
	localparam int MEM_DEPTH = 16;
	localparam int OP_W = 4;
	localparam int BIT_W = 3;
	// register byte offsets
	localparam logic [ADDR_W-1:0] OFF_CMD = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_WORK = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_FLAGS = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_IO = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_MEM = 8'h40;
	localparam logic [ADDR_W-1:0] OFF_MEM_END = 8'h80;
	// command word fields
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_BIT_LSB = 4;
	localparam int CMD_MEM_OPND = 8;
	localparam int CMD_MEM_DEST = 9;
	localparam int CMD_IMM_LSB = 16;
	localparam int CMD_ADDR_LSB = 24;
	// reset values
	localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
	localparam logic [DATA_W-1:0] ONE_BYTE = 8'h01;
	localparam logic [BUS_W-1:0] ZERO_WORD = 32'h00000000;
	localparam logic [ALIGN_W-1:0] ALIGNED = 2'h0;

	typedef struct packed {
		logic signed_wrap_flag;
		logic half_result_flag;
		logic arith_bit_out_flag;
		logic result_nil_flag;
	} flags_t;

	localparam flags_t FLAGS_RESET = 4'h0;

	typedef enum logic [OP_W-1:0] {
		op_nop = 4'h0,
		op_shift_right_zero_fill = 4'h1,
		op_rotate_right_carry = 4'h2,
		op_shift_left_zero_fill = 4'h3,
		op_rotate_left_carry = 4'h4,
		op_nibble_swap = 4'h5,
		op_and = 4'h6,
		op_or = 4'h7,
		op_xor = 4'h8,
		op_negate = 4'h9,
		op_io_clear_bit_op = 4'hA,
		op_io_force_bit_high_op = 4'hB,
		op_mem_clear_bit_op = 4'hC,
		op_mem_force_bit_high_op = 4'hD
	} op_t;
endpackage : alu_pkg

// *** alu_if.sv ***
// operands, command and results passed between register side and datapath
// assumes both ends sit in the same clock domain
`timescale 1ns/100ps
interface alu_if;
	import alu_pkg::*;
	op_t op;
	logic [BIT_W-1:0] bit_sel;
	logic mem_operand;
	logic mem_dest;
	logic [DATA_W-1:0] imm;
	logic [DATA_W-1:0] work;
	logic [DATA_W-1:0] mem_byte;
	logic [DATA_W-1:0] io_byte;
	flags_t flags_in;
	logic [DATA_W-1:0] result;
	logic wr_work;
	logic wr_mem;
	logic wr_io;
	flags_t flags_out;
	modport unit (input op, bit_sel, mem_operand, mem_dest, imm, work, mem_byte, io_byte,
		flags_in, output result, wr_work, wr_mem, wr_io, flags_out);
	modport ctrl (output op, bit_sel, mem_operand, mem_dest, imm, work, mem_byte, io_byte,
		flags_in, input result, wr_work, wr_mem, wr_io, flags_out);
endinterface : alu_if

// *** alu_unit.sv ***
// combinational shift, logic, negate and single-bit datapath
// assumes the caller commits result only when a write strobe is set, and flags on every command
`timescale 1ns/100ps
module alu_unit (
	alu_if.unit bus // operands in, result and strobes out
);
	import alu_pkg::*;
	logic [DATA_W-1:0] opnd;
	logic [DATA_W-1:0] mask;
	logic [DATA_W-1:0] res;
	flags_t fl;
	logic wk;
	logic wm;
	logic wi;

	always_comb begin
		opnd = bus.mem_operand ? bus.mem_byte : bus.work;
		mask = DATA_W'(ONE_BYTE << bus.bit_sel); // [RULE21]
		res = opnd;
		fl = bus.flags_in;
		wk = 1'b0;
		wm = 1'b0;
		wi = 1'b0;
		case (bus.op)
			op_shift_right_zero_fill: begin
				res = {1'b0, opnd[MSB:1]}; // [RULE1] [RULE3]
				fl.arith_bit_out_flag = opnd[0]; // [RULE8]
				wm = bus.mem_operand;
				wk = !bus.mem_operand;
			end
			op_rotate_right_carry: begin
				res = {bus.flags_in.arith_bit_out_flag, opnd[MSB:1]}; // [RULE2] [RULE3]
				fl.arith_bit_out_flag = opnd[0];
				wm = bus.mem_operand;
				wk = !bus.mem_operand;
			end
			op_shift_left_zero_fill: begin
				res = {opnd[MSB-1:0], 1'b0}; // [RULE4] [RULE6]
				fl.arith_bit_out_flag = opnd[MSB];
				wm = bus.mem_operand;
				wk = !bus.mem_operand;
			end
			op_rotate_left_carry: begin
				res = {opnd[MSB-1:0], bus.flags_in.arith_bit_out_flag}; // [RULE5] [RULE7]
				fl.arith_bit_out_flag = opnd[MSB];
				wm = bus.mem_operand;
				wk = !bus.mem_operand;
			end
			op_nibble_swap: begin
				res = {bus.work[NIB-1:0], bus.work[MSB:NIB]}; // [RULE9]
				wk = 1'b1;
			end
			op_and, op_or: begin
				// a memory destination always takes the memory byte as operand
				opnd = (bus.mem_operand || bus.mem_dest) ? bus.mem_byte : bus.imm;
				res = (bus.op == op_and) ? (bus.work & opnd) : (bus.work | opnd); // [RULE10] [RULE11]
				fl.result_nil_flag = (res == ZERO_BYTE); // [RULE13] [RULE20]
				wm = bus.mem_dest;
				wk = !bus.mem_dest;
			end
			op_xor: begin
				res = bus.work ^ bus.imm; // [RULE12]
				fl.result_nil_flag = (res == ZERO_BYTE);
				wk = 1'b1;
			end
			op_negate: begin
				res = DATA_W'(~bus.mem_byte + ONE_BYTE); // [RULE14]
				fl.result_nil_flag = (res == ZERO_BYTE);
				wm = 1'b1;
			end
			op_io_clear_bit_op: begin
				res = bus.io_byte & ~mask; // [RULE15]
				wi = 1'b1;
			end
			op_io_force_bit_high_op: begin
				res = bus.io_byte | mask; // [RULE16]
				wi = 1'b1;
			end
			op_mem_clear_bit_op: begin
				res = bus.mem_byte & ~mask; // [RULE17] [RULE19]
				wm = 1'b1;
			end
			op_mem_force_bit_high_op: begin
				res = bus.mem_byte | mask; // [RULE18]
				wm = 1'b1;
			end
			default: begin
				res = opnd;
			end
		endcase
		bus.result = res;
		bus.flags_out = fl;
		bus.wr_work = wk;
		bus.wr_mem = wm;
		bus.wr_io = wi;
	end
endmodule : alu_unit

// *** shift_logic_bit_alu.sv ***
// register side of the shift/logic/bit datapath: Avalon-MM slave, work register,
// flags, io port register and data memory, with one command register that executes
// assumes a master that holds each request until it samples waitrequest low
//
// Notes on behaviour
// [RULE1] right shift work register, zero into bit 7
// [RULE2] right rotate through carry flag, work register
// [RULE3] both right shifts also on memory byte
// [RULE4] left shift work register, zero into bit 0
// [RULE5] left rotate through carry flag, work register
// [RULE6] left shift on memory byte, written back
// [RULE7] left rotate through carry on memory byte
// [RULE8] shifts and rotates touch only carry flag
// [RULE9] nibble swap of work register, flags kept
// [RULE10] and with immediate or memory byte
// [RULE11] or with immediate or memory byte
// [RULE12] xor of work register with immediate
// [RULE13] logic ops and negate touch only nil
// [RULE14] negate memory byte in two's complement
// [RULE15] clear selected io port bit only
// [RULE16] set selected io port bit only
// [RULE17] clear selected memory bit only
// [RULE18] set selected memory bit only
// [RULE19] bit operations leave all flags unchanged
// [RULE20] nil flag set when result is zero
// [RULE21] three-bit index; rotates use old carry
//
// The implementer's own choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/100ps
module shift_logic_bit_alu (
	input wire logic clk, // core clock, 100 MHz
	input wire logic rst, // asynchronous reset, active high
	input wire logic [alu_pkg::ADDR_W-1:0] avs_address, // byte address
	input wire logic avs_read, // read request
	input wire logic avs_write, // write request
	input wire logic [alu_pkg::BUS_W-1:0] avs_writedata, // write data
	output logic [alu_pkg::BUS_W-1:0] avs_readdata, // read data
	output logic avs_waitrequest, // low for one cycle to finish a request
	output logic [alu_pkg::DATA_W-1:0] io_port // io port register
);
	import alu_pkg::*;

	alu_if bus ();

	logic waitrequest_q;
	logic [BUS_W-1:0] readdata_q;
	logic [BUS_W-1:0] cmd_q;
	logic [DATA_W-1:0] work_q;
	flags_t flags_q;
	logic [DATA_W-1:0] io_q;
	logic [DATA_W-1:0] mem_q [MEM_DEPTH];

	logic access;
	logic wr_commit;
	logic mem_hit;
	logic [MEM_ADDR_W-1:0] mem_idx;
	logic cmd_fire;
	op_t c_op;
	logic [BIT_W-1:0] c_bit;
	logic c_mopnd;
	logic c_mdest;
	logic [DATA_W-1:0] c_imm;
	logic [MEM_ADDR_W-1:0] c_addr;
	logic [DATA_W-1:0] rd_byte;

	assign access = avs_read || avs_write;
	// a write takes effect at the edge where waitrequest is seen low
	assign wr_commit = avs_write && !waitrequest_q;
	assign mem_hit = (avs_address >= OFF_MEM) && (avs_address < OFF_MEM_END)
		&& (avs_address[ALIGN_W-1:0] == ALIGNED);
	assign mem_idx = avs_address[ALIGN_W +: MEM_ADDR_W];
	assign cmd_fire = wr_commit && (avs_address == OFF_CMD);

	assign c_op = op_t'(avs_writedata[CMD_OP_LSB +: OP_W]);
	assign c_bit = avs_writedata[CMD_BIT_LSB +: BIT_W];
	assign c_mopnd = avs_writedata[CMD_MEM_OPND];
	assign c_mdest = avs_writedata[CMD_MEM_DEST];
	assign c_imm = avs_writedata[CMD_IMM_LSB +: DATA_W];
	assign c_addr = avs_writedata[CMD_ADDR_LSB +: MEM_ADDR_W];
	assign rd_byte = mem_q[c_addr];

	// datapath sees an operation only in the cycle the command commits
	assign bus.op = cmd_fire ? c_op : op_nop;
	assign bus.bit_sel = c_bit;
	assign bus.mem_operand = c_mopnd;
	assign bus.mem_dest = c_mdest;
	assign bus.imm = c_imm;
	assign bus.work = work_q;
	assign bus.mem_byte = rd_byte;
	assign bus.io_byte = io_q;
	assign bus.flags_in = flags_q; // [RULE21]

	alu_unit u_alu (
		.bus(bus)
	);

	assign avs_waitrequest = waitrequest_q;
	assign avs_readdata = readdata_q;
	assign io_port = io_q;

	// every access is answered one cycle after it is seen
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			waitrequest_q <= 1'b1;
		end else if (access && waitrequest_q) begin
			waitrequest_q <= 1'b0;
		end else begin
			waitrequest_q <= 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			readdata_q <= ZERO_WORD;
		end else if (avs_read && waitrequest_q) begin
			if (mem_hit) begin
				readdata_q <= BUS_W'(mem_q[mem_idx]);
			end else begin
				case (avs_address)
					OFF_CMD: begin
						readdata_q <= cmd_q;
					end
					OFF_WORK: begin
						readdata_q <= BUS_W'(work_q);
					end
					OFF_FLAGS: begin
						readdata_q <= BUS_W'(flags_q);
					end
					OFF_IO: begin
						readdata_q <= BUS_W'(io_q);
					end
					default: begin
						readdata_q <= ZERO_WORD;
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cmd_q <= ZERO_WORD;
		end else if (cmd_fire) begin
			cmd_q <= avs_writedata;
		end
	end

	// a committing command wins over nothing else: it is the only write in its cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			work_q <= ZERO_BYTE;
		end else if (cmd_fire && bus.wr_work) begin
			work_q <= bus.result; // [RULE1] [RULE2] [RULE4] [RULE5] [RULE9] [RULE10] [RULE12]
		end else if (wr_commit && (avs_address == OFF_WORK)) begin
			work_q <= avs_writedata[DATA_W-1:0];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flags_q <= FLAGS_RESET;
		end else if (cmd_fire) begin
			flags_q <= bus.flags_out; // [RULE8] [RULE13] [RULE19]
		end else if (wr_commit && (avs_address == OFF_FLAGS)) begin
			flags_q <= flags_t'(avs_writedata[$bits(flags_t)-1:0]);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			io_q <= ZERO_BYTE;
		end else if (cmd_fire && bus.wr_io) begin
			io_q <= bus.result; // [RULE15] [RULE16]
		end else if (wr_commit && (avs_address == OFF_IO)) begin
			io_q <= avs_writedata[DATA_W-1:0];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < MEM_DEPTH; i++) begin
				mem_q[i] <= ZERO_BYTE;
			end
		end else if (cmd_fire && bus.wr_mem) begin
			mem_q[c_addr] <= bus.result; // [RULE3] [RULE6] [RULE7] [RULE14] [RULE17] [RULE18]
		end else if (wr_commit && mem_hit) begin
			mem_q[mem_idx] <= avs_writedata[DATA_W-1:0];
		end
	end

	// helper terms for the checks below
	logic is_shift;
	logic is_logic;
	logic is_bitop;
	logic [DATA_W-1:0] and_or_b;
	logic [DATA_W-1:0] bmask;
	assign is_shift = cmd_fire && (c_op inside {op_shift_right_zero_fill,
		op_rotate_right_carry, op_shift_left_zero_fill, op_rotate_left_carry});
	assign is_logic = cmd_fire && (c_op inside {op_and, op_or, op_xor, op_negate});
	assign is_bitop = cmd_fire && (c_op inside {op_io_clear_bit_op,
		op_io_force_bit_high_op, op_mem_clear_bit_op, op_mem_force_bit_high_op});
	assign and_or_b = (c_mopnd || c_mdest) ? rd_byte : c_imm;
	assign bmask = DATA_W'(ONE_BYTE << c_bit);

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	property p_shr_work;
		cmd_fire && c_op == op_shift_right_zero_fill && !c_mopnd |=>
			work_q == ($past(work_q) >> 1) && flags_q.arith_bit_out_flag == $past(work_q[0]);
	endproperty
	a_shr_work: assert property (p_shr_work) else $error("right shift of work wrong"); // [RULE1]

	property p_rrc_work;
		cmd_fire && c_op == op_rotate_right_carry && !c_mopnd |=>
			work_q == {$past(flags_q.arith_bit_out_flag), $past(work_q[MSB:1])}
			&& flags_q.arith_bit_out_flag == $past(work_q[0]);
	endproperty
	a_rrc_work: assert property (p_rrc_work) else $error("right rotate of work wrong"); // [RULE2]

	property p_shr_mem;
		cmd_fire && c_mopnd && (c_op inside {op_shift_right_zero_fill, op_rotate_right_carry})
			|=> mem_q[$past(c_addr)] == {$past(c_op == op_rotate_right_carry
			&& flags_q.arith_bit_out_flag), $past(rd_byte[MSB:1])}
			&& flags_q.arith_bit_out_flag == $past(rd_byte[0]);
	endproperty
	a_shr_mem: assert property (p_shr_mem) else $error("right shift of memory wrong"); // [RULE3]

	property p_shl_work;
		cmd_fire && c_op == op_shift_left_zero_fill && !c_mopnd |=>
			work_q == DATA_W'($past(work_q) << 1)
			&& flags_q.arith_bit_out_flag == $past(work_q[MSB]);
	endproperty
	a_shl_work: assert property (p_shl_work) else $error("left shift of work wrong"); // [RULE4]

	property p_rlc_work;
		cmd_fire && c_op == op_rotate_left_carry && !c_mopnd |=>
			work_q == {$past(work_q[MSB-1:0]), $past(flags_q.arith_bit_out_flag)}
			&& flags_q.arith_bit_out_flag == $past(work_q[MSB]);
	endproperty
	a_rlc_work: assert property (p_rlc_work) else $error("left rotate of work wrong"); // [RULE5]

	property p_shl_mem;
		cmd_fire && c_op == op_shift_left_zero_fill && c_mopnd |=>
			mem_q[$past(c_addr)] == DATA_W'($past(rd_byte) << 1)
			&& flags_q.arith_bit_out_flag == $past(rd_byte[MSB]);
	endproperty
	a_shl_mem: assert property (p_shl_mem) else $error("left shift of memory wrong"); // [RULE6]

	property p_rlc_mem;
		cmd_fire && c_op == op_rotate_left_carry && c_mopnd |=>
			mem_q[$past(c_addr)] == {$past(rd_byte[MSB-1:0]), $past(flags_q.arith_bit_out_flag)};
	endproperty
	a_rlc_mem: assert property (p_rlc_mem) else $error("left rotate of memory wrong"); // [RULE7]

	property p_shift_flags;
		is_shift |=> {flags_q.result_nil_flag, flags_q.half_result_flag,
			flags_q.signed_wrap_flag} == $past({flags_q.result_nil_flag,
			flags_q.half_result_flag, flags_q.signed_wrap_flag});
	endproperty
	a_shift_flags: assert property (p_shift_flags) else $error("shift changed other flags"); // [RULE8]

	property p_swap;
		cmd_fire && c_op == op_nibble_swap |=>
			work_q == {$past(work_q[NIB-1:0]), $past(work_q[MSB:NIB])} && $stable(flags_q);
	endproperty
	a_swap: assert property (p_swap) else $error("nibble swap wrong"); // [RULE9]

	property p_and;
		cmd_fire && c_op == op_and && !c_mdest |=> work_q == ($past(work_q) & $past(and_or_b));
	endproperty
	a_and: assert property (p_and) else $error("and result wrong"); // [RULE10]

	property p_and_mem;
		cmd_fire && c_op == op_and && c_mdest |=>
			mem_q[$past(c_addr)] == ($past(work_q) & $past(rd_byte));
	endproperty
	a_and_mem: assert property (p_and_mem) else $error("and to memory wrong"); // [RULE10]

	property p_or_work;
		cmd_fire && c_op == op_or && !c_mdest |=> work_q == ($past(work_q) | $past(and_or_b));
	endproperty
	a_or_work: assert property (p_or_work) else $error("or to work wrong"); // [RULE11]

	property p_or_mem;
		cmd_fire && c_op == op_or && c_mdest |=>
			mem_q[$past(c_addr)] == ($past(work_q) | $past(rd_byte));
	endproperty
	a_or_mem: assert property (p_or_mem) else $error("or to memory wrong"); // [RULE11]

	property p_xor;
		cmd_fire && c_op == op_xor |=> work_q == ($past(work_q) ^ $past(c_imm));
	endproperty
	a_xor: assert property (p_xor) else $error("xor result wrong"); // [RULE12]

	property p_logic_flags;
		is_logic |=> {flags_q.arith_bit_out_flag, flags_q.half_result_flag,
			flags_q.signed_wrap_flag} == $past({flags_q.arith_bit_out_flag,
			flags_q.half_result_flag, flags_q.signed_wrap_flag});
	endproperty
	a_logic_flags: assert property (p_logic_flags) else $error("logic op changed flags"); // [RULE13]

	property p_neg;
		cmd_fire && c_op == op_negate |=>
			DATA_W'(mem_q[$past(c_addr)] + $past(rd_byte)) == ZERO_BYTE;
	endproperty
	a_neg: assert property (p_neg) else $error("negate wrong"); // [RULE14]

	property p_io_clr;
		cmd_fire && c_op == op_io_clear_bit_op |=> io_q == ($past(io_q) & ~$past(bmask));
	endproperty
	a_io_clr: assert property (p_io_clr) else $error("io bit clear wrong"); // [RULE15]

	property p_io_set;
		cmd_fire && c_op == op_io_force_bit_high_op |=> io_q == ($past(io_q) | $past(bmask));
	endproperty
	a_io_set: assert property (p_io_set) else $error("io bit set wrong"); // [RULE16]

	property p_mem_clr;
		cmd_fire && c_op == op_mem_clear_bit_op |=>
			mem_q[$past(c_addr)] == ($past(rd_byte) & ~$past(bmask));
	endproperty
	a_mem_clr: assert property (p_mem_clr) else $error("memory bit clear wrong"); // [RULE17]

	property p_mem_set;
		cmd_fire && c_op == op_mem_force_bit_high_op |=>
			mem_q[$past(c_addr)] == ($past(rd_byte) | $past(bmask));
	endproperty
	a_mem_set: assert property (p_mem_set) else $error("memory bit set wrong"); // [RULE18]

	property p_bit_flags;
		is_bitop |=> $stable(flags_q);
	endproperty
	a_bit_flags: assert property (p_bit_flags) else $error("bit op changed flags"); // [RULE19]

	property p_nil;
		is_logic |=> flags_q.result_nil_flag
			== (($past(bus.wr_mem) ? mem_q[$past(c_addr)] : work_q) == ZERO_BYTE);
	endproperty
	a_nil: assert property (p_nil) else $error("nil flag wrong"); // [RULE20]

	property p_bit_index;
		cmd_fire && c_op == op_io_force_bit_high_op |=> io_q[$past(c_bit)] == 1'b1;
	endproperty
	a_bit_index: assert property (p_bit_index) else $error("bit index wrong"); // [RULE21]

	property p_answer;
		access && waitrequest_q |=> !waitrequest_q ##1 waitrequest_q;
	endproperty
	a_answer: assert property (p_answer) else $error("bus answer timing wrong");
endmodule : shift_logic_bit_alu

// *** core_bus_master.sv ***
// far-side model: core bus master issuing one Avalon-MM request at a time
// assumes a slave that drops waitrequest once to finish each request
`timescale 1ns/100ps
module core_bus_master (
	input wire logic clk, // core clock
	input wire logic avs_waitrequest, // slave stall
	output logic [alu_pkg::ADDR_W-1:0] avs_address, // byte address
	output logic avs_read, // read request
	output logic avs_write, // write request
	output logic [alu_pkg::BUS_W-1:0] avs_writedata // write data
);
	import alu_pkg::*;
	initial begin
		avs_address = OFF_CMD;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = ZERO_WORD;
	end
	// entered right after a rising edge, returns right after one
	task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [BUS_W-1:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		// released lines show the inverse so a stale value is never taken as live
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		avs_address <= ~a;
		avs_writedata <= ~d;
		@(posedge clk);
	endtask : xfer
endmodule : core_bus_master

// *** shift_logic_bit_alu_bench.sv ***
// self-checking bench of the shift/logic/bit datapath through its register bus
// assumes the package, interface, design and bus master model compiled first
`timescale 1ns/100ps
module shift_logic_bit_alu_bench;
	import alu_pkg::*;
	typedef struct {string name; logic [BUS_W-1:0] v;} note_t;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [ADDR_W-1:0] avs_address;
	logic avs_read, avs_write, avs_waitrequest;
	logic [BUS_W-1:0] avs_writedata, avs_readdata;
	logic [DATA_W-1:0] io_port, w, io;
	logic [DATA_W-1:0] m [MEM_DEPTH];
	flags_t fl;
	note_t notes[$];
	note_t nt;
	int n_fail = 0;
	int tests_run = 0;
	int cyc = 0;
	always #5 clk = ~clk;
	shift_logic_bit_alu dut_u (.clk(clk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .io_port(io_port));
	core_bus_master host_u (.clk(clk), .avs_waitrequest(avs_waitrequest),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata));
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : give_verdict
	task automatic chk(input string nm, input logic [BUS_W-1:0] seen, input logic [BUS_W-1:0] e);
		tests_run++;
		if (seen !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, e, seen);
		end
	endtask : chk
	// read monitor: each finished read is judged against the oldest note
	always @(posedge clk) begin
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
			if (notes.size() == 0) begin
				n_fail++;
				$display("wrong value read expected none seen %h", avs_readdata);
			end else begin
				nt = notes.pop_front();
				chk(nt.name, avs_readdata, nt.v);
			end
		end
		cyc++;
		if (cyc == 40000) begin
			n_fail++;
			give_verdict();
		end
	end
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [BUS_W-1:0] d);
		host_u.xfer(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [ADDR_W-1:0] a, input string nm, input logic [BUS_W-1:0] e);
		notes.push_back('{nm, e});
		host_u.xfer(1'b0, a, ZERO_WORD);
	endtask : rd
	function automatic logic [ADDR_W-1:0] moff(input logic [3:0] i);
		return OFF_MEM + ADDR_W'({i, 2'b00});
	endfunction : moff
	// preset operands and flags, run one command, read every place back
	task automatic step(input op_t op, input logic mo, input logic md,
		input logic [7:0] imm, input logic [7:0] a, input logic [7:0] b);
		logic [3:0] ix;
		logic [2:0] n;
		logic [7:0] s, r;
		logic dm;
		logic [BUS_W-1:0] cw;
		ix = 4'($urandom);
		n = 3'($urandom);
		w = a;
		m[ix] = b;
		io = 8'($urandom);
		fl = flags_t'(4'($urandom));
		wr(OFF_WORK, {24'h000000, w});
		wr(OFF_FLAGS, {28'h0000000, fl});
		wr(moff(ix), {24'h000000, m[ix]});
		wr(OFF_IO, {24'h000000, io});
		dm = op inside {op_negate, op_mem_clear_bit_op, op_mem_force_bit_high_op};
		s = (mo || md || dm) ? m[ix] : w;
		dm = dm || (mo && op inside {[op_shift_right_zero_fill:op_rotate_left_carry]});
		dm = dm || (md && op inside {op_and, op_or});
		r = s;
		case (op)
			op_shift_right_zero_fill: r = {1'b0, s[7:1]};
			op_rotate_right_carry: r = {fl.arith_bit_out_flag, s[7:1]};
			op_shift_left_zero_fill: r = {s[6:0], 1'b0};
			op_rotate_left_carry: r = {s[6:0], fl.arith_bit_out_flag};
			op_nibble_swap: r = {w[3:0], w[7:4]};
			op_and: r = w & ((mo || md) ? s : imm);
			op_or: r = w | ((mo || md) ? s : imm);
			op_xor: r = w ^ imm;
			op_negate: r = 8'h00 - s;
			op_io_clear_bit_op: r = io & ~(8'h01 << n);
			op_io_force_bit_high_op: r = io | (8'h01 << n);
			op_mem_clear_bit_op: r[n] = 1'b0;
			op_mem_force_bit_high_op: r[n] = 1'b1;
			default: r = s;
		endcase
		if (op inside {op_shift_right_zero_fill, op_rotate_right_carry}) fl.arith_bit_out_flag = s[0];
		if (op inside {op_shift_left_zero_fill, op_rotate_left_carry}) fl.arith_bit_out_flag = s[7];
		if (op inside {op_and, op_or, op_xor, op_negate}) fl.result_nil_flag = (r == 8'h00);
		if (op inside {op_io_clear_bit_op, op_io_force_bit_high_op}) io = r;
		else if (dm) m[ix] = r;
		else if (op != op_nop) w = r;
		cw = {4'h0, ix, imm, 6'h00, md, mo, 1'b0, n, op};
		wr(OFF_CMD, cw);
		rd(OFF_CMD, "command", cw);
		rd(OFF_WORK, "work", {24'h000000, w});
		rd(OFF_FLAGS, "flags", {28'h0000000, fl});
		rd(moff(ix), "memory", {24'h000000, m[ix]});
		rd(OFF_IO, "io", {24'h000000, io});
		chk("io_port", {24'h000000, io_port}, {24'h000000, io});
	endtask : step
	task automatic rnd(input op_t op, input logic mo, input logic md);
		repeat (6) step(op, mo, md, 8'($urandom), 8'($urandom), 8'($urandom));
	endtask : rnd
	initial begin
		void'($urandom(32'h4F3D));
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(OFF_CMD, "reset command", ZERO_WORD);
		rd(OFF_WORK, "reset work", ZERO_WORD);
		rd(OFF_FLAGS, "reset flags", ZERO_WORD);
		rd(OFF_IO, "reset io", ZERO_WORD);
		rd(moff(4'hF), "reset memory", ZERO_WORD);
		chk("reset io_port", {24'h000000, io_port}, ZERO_WORD);
		$display("test reset values done");
		wr(8'h10, 32'hFFFFFFFF);
		rd(8'h10, "unmapped", ZERO_WORD);
		rd(8'h41, "misaligned memory", ZERO_WORD);
		rd(OFF_MEM_END, "past memory", ZERO_WORD);
		wr(OFF_FLAGS, 32'hFFFFFFFF);
		rd(OFF_FLAGS, "flags reserved bits", 32'h0000000F);
		$display("test bus map done");
		rnd(op_shift_right_zero_fill, 1'b0, 1'b0);
		rnd(op_rotate_right_carry, 1'b0, 1'b0);
		rnd(op_shift_right_zero_fill, 1'b1, 1'b0);
		rnd(op_rotate_right_carry, 1'b1, 1'b0);
		rnd(op_shift_left_zero_fill, 1'b0, 1'b0);
		rnd(op_rotate_left_carry, 1'b0, 1'b0);
		rnd(op_shift_left_zero_fill, 1'b1, 1'b0);
		rnd(op_rotate_left_carry, 1'b1, 1'b0);
		rnd(op_nibble_swap, 1'b0, 1'b0);
		$display("test shifts done");
		rnd(op_and, 1'b0, 1'b0);
		rnd(op_and, 1'b1, 1'b0);
		rnd(op_and, 1'b1, 1'b1);
		rnd(op_or, 1'b0, 1'b0);
		rnd(op_or, 1'b1, 1'b0);
		rnd(op_or, 1'b1, 1'b1);
		rnd(op_xor, 1'b0, 1'b0);
		rnd(op_negate, 1'b0, 1'b0);
		step(op_and, 1'b0, 1'b0, 8'h00, 8'hA5, 8'h3C);
		step(op_or, 1'b1, 1'b1, 8'hFF, 8'h00, 8'h00);
		step(op_xor, 1'b0, 1'b0, 8'h5A, 8'h5A, 8'h00);
		step(op_negate, 1'b0, 1'b0, 8'h00, 8'h11, 8'h00);
		step(op_negate, 1'b0, 1'b0, 8'h00, 8'h11, 8'h80);
		$display("test logic done");
		rnd(op_io_clear_bit_op, 1'b0, 1'b0);
		rnd(op_io_force_bit_high_op, 1'b0, 1'b0);
		rnd(op_mem_clear_bit_op, 1'b0, 1'b0);
		rnd(op_mem_force_bit_high_op, 1'b0, 1'b0);
		rnd(op_nop, 1'b0, 1'b0);
		$display("test bit operations done");
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(OFF_WORK, "work after second reset", ZERO_WORD);
		rd(OFF_IO, "io after second reset", ZERO_WORD);
		chk("io_port after second reset", {24'h000000, io_port}, ZERO_WORD);
		$display("test second reset done");
		give_verdict();
	end
endmodule : shift_logic_bit_alu_bench
